//--- src/i2o_queue_pointer_unit.sv
`timescale 1ns/100ps
`default_nettype none

module i2o_queue_pointer_unit
    import queue_ptr_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_B,
    // settings held by the neighbouring control registers
    input wire logic [11:0] QUEUE_BASE,
    input wire logic [2:0] QUEUE_SIZE,
    input wire logic [2:0] HOST_LIST_SIZE,
    input wire logic MSG_UNIT_ENABLE,
    input wire logic EXT_OUTBOUND_ENABLE,
    // local processor register port
    input wire logic REG_SEL,
    input wire logic REG_WRITE,
    input wire logic [11:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    output logic REG_ACK,
    output logic REG_HIT,
    // PCI message target image port
    input wire logic PCI_TGT_VALID,
    input wire logic PCI_TGT_WRITE,
    input wire logic [11:0] PCI_TGT_ADDR,
    input wire logic [31:0] PCI_TGT_WDATA,
    output logic [31:0] PCI_TGT_RDATA,
    output logic PCI_TGT_DONE,
    output logic PCI_TGT_RETRY,
    output logic PCI_TGT_CLAIM,
    // status toward the rest of the message unit
    output logic OUTBOUND_LIST_IRQ_STATUS,
    output logic OUTBOUND_FREE_EMPTY,
    output logic OUTBOUND_POST_EMPTY,
    output logic [17:0] INBOUND_POST_HEAD
);

    state_s st;
    state_s next_st;
    logic reg_wr;
    logic tgt_live;
    logic tgt_host;
    logic tgt_inq;
    logic tgt_outq;
    logic idx_differ;
    logic [29:0] q_mask;
    logic [29:0] h_mask;
    logic [NUM_PTR-1:0] bump;
    logic [NUM_PTR-1:0] load;
    logic [NUM_PTR-1:0][29:0] step_word;
    logic [NUM_PTR-1:0][29:0] load_word;

    ////////////////////////////////////////////////////////////////////////////////
    // request decode

    assign reg_wr = REG_SEL && REG_WRITE;
    assign q_mask = queue_mask(QUEUE_SIZE);
    assign h_mask = host_mask(HOST_LIST_SIZE);
    assign tgt_live = PCI_TGT_VALID && MSG_UNIT_ENABLE;
    assign tgt_inq = tgt_live && (PCI_TGT_ADDR == TGT_INBOUND_QUEUE);
    assign tgt_outq = tgt_live && (PCI_TGT_ADDR == TGT_OUTBOUND_QUEUE);
    // offset is taken as word aligned; a queue-port collision is not policed
    assign tgt_host = tgt_live
        && (PCI_TGT_ADDR[HOST_OFS_MSB:WORD_LSB] == st.host_ofs);

    assign bump[PTR_IPL_HEAD] = tgt_inq && PCI_TGT_WRITE;
    assign bump[PTR_OFL_HEAD] = tgt_outq && PCI_TGT_WRITE;
    assign bump[PTR_OPL_TAIL] = tgt_outq && !PCI_TGT_WRITE;
    // step registers act only on a one in the step bit
    assign bump[PTR_OFL_TAIL] = reg_wr && (REG_ADDR == OFS_OFL_TAIL_STEP)
        && REG_WDATA[STEP_BIT];
    assign bump[PTR_OPL_HEAD] = reg_wr && (REG_ADDR == OFS_OPL_HEAD_STEP)
        && REG_WDATA[STEP_BIT];
    assign bump[PTR_PROC_INDEX] = reg_wr && (REG_ADDR == OFS_PROC_INDEX_STEP)
        && REG_WDATA[STEP_BIT];

    assign idx_differ = EXT_OUTBOUND_ENABLE && (st.hoia != st.ptr[PTR_PROC_INDEX]);

    ////////////////////////////////////////////////////////////////////////////////
    // one stepper per pointer

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PTR; gi++) begin : g_ptr
            assign load[gi] = reg_wr && (REG_ADDR == slot_offset(gi));
            if (gi == PTR_PROC_INDEX) begin : g_index
                assign load_word[gi] = REG_WDATA[31:WORD_LSB];
                word_stepper u_step (
                    .word(st.ptr[gi]),
                    .wrap_mask(h_mask),
                    .stepped(step_word[gi])
                );
            end else begin : g_queue
                assign load_word[gi] = {14'h0000, REG_WDATA[QPTR_MSB:WORD_LSB]};
                word_stepper u_step (
                    .word(st.ptr[gi]),
                    .wrap_mask(q_mask),
                    .stepped(step_word[gi])
                );
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // register read mux

    function automatic logic [31:0] ptr_view(input logic [29:0] word, input logic [11:0] base);
        ptr_view = {base, 2'b00, word[15:0], 2'b00};
    endfunction

    function automatic logic [31:0] read_word(input logic [11:0] addr, input state_s s,
                                              input logic [11:0] base);
        if (addr == OFS_IPL_HEAD) read_word = ptr_view(s.ptr[PTR_IPL_HEAD], base);
        else if (addr == OFS_OFL_TAIL) read_word = ptr_view(s.ptr[PTR_OFL_TAIL], base);
        else if (addr == OFS_OFL_HEAD) read_word = ptr_view(s.ptr[PTR_OFL_HEAD], base);
        else if (addr == OFS_OPL_TAIL) read_word = ptr_view(s.ptr[PTR_OPL_TAIL], base);
        else if (addr == OFS_OPL_HEAD) read_word = ptr_view(s.ptr[PTR_OPL_HEAD], base);
        else if (addr == OFS_HOST_OFFSET) read_word = {20'h00000, s.host_ofs, 2'b00};
        else if (addr == OFS_HOST_INDEX) read_word = {s.hoia, 2'b00};
        else if (addr == OFS_PROC_INDEX) read_word = {s.ptr[PTR_PROC_INDEX], 2'b00};
        else read_word = 32'h00000000; // step registers and unmapped read zero
    endfunction

    function automatic logic mapped(input logic [11:0] addr);
        mapped = (addr >= OFS_IPL_HEAD) && (addr <= OFS_PROC_INDEX_STEP)
            && (addr[1:0] == 2'b00);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_st = st;
        next_st.reg_ack = 1'b0;
        next_st.reg_hit = 1'b0;
        next_st.tgt_done = 1'b0;
        next_st.tgt_retry = 1'b0;
        next_st.tgt_claim = 1'b0;
        // a software load beats a same-cycle bump: it is an initialisation
        for (int i = 0; i < NUM_PTR; i++) begin
            if (load[i]) begin
                next_st.ptr[i] = load_word[i];
            end else if (bump[i]) begin
                next_st.ptr[i] = step_word[i];
            end
        end
        if (reg_wr && (REG_ADDR == OFS_HOST_OFFSET)) begin
            next_st.host_ofs = REG_WDATA[HOST_OFS_MSB:WORD_LSB];
        end
        // the host owns this index, so its write wins a same-cycle collision
        if (tgt_host && PCI_TGT_WRITE) begin
            next_st.hoia = PCI_TGT_WDATA[31:WORD_LSB];
        end else if (reg_wr && (REG_ADDR == OFS_HOST_INDEX)) begin
            next_st.hoia = REG_WDATA[31:WORD_LSB];
        end
        next_st.irq = idx_differ;
        // equal head and tail is empty; software loads them equal to start
        next_st.ofl_empty = (st.ptr[PTR_OFL_HEAD] == st.ptr[PTR_OFL_TAIL]);
        next_st.opl_empty = (st.ptr[PTR_OPL_HEAD] == st.ptr[PTR_OPL_TAIL]);
        if (REG_SEL) begin
            next_st.reg_ack = 1'b1;
            next_st.reg_hit = mapped(REG_ADDR);
            next_st.reg_rdata = REG_WRITE ? 32'h00000000 : read_word(REG_ADDR, st, QUEUE_BASE);
        end
        if (PCI_TGT_VALID) begin
            next_st.tgt_retry = !MSG_UNIT_ENABLE;
            next_st.tgt_done = MSG_UNIT_ENABLE;
            next_st.tgt_claim = tgt_host || tgt_inq || tgt_outq;
            next_st.tgt_rdata = (tgt_host && !PCI_TGT_WRITE) ? {st.hoia, 2'b00} : 32'h00000000;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign REG_RDATA = st.reg_rdata;
    assign REG_ACK = st.reg_ack;
    assign REG_HIT = st.reg_hit;
    assign PCI_TGT_RDATA = st.tgt_rdata;
    assign PCI_TGT_DONE = st.tgt_done;
    assign PCI_TGT_RETRY = st.tgt_retry;
    assign PCI_TGT_CLAIM = st.tgt_claim;
    assign OUTBOUND_LIST_IRQ_STATUS = st.irq;
    assign OUTBOUND_FREE_EMPTY = st.ofl_empty;
    assign OUTBOUND_POST_EMPTY = st.opl_empty;
    assign INBOUND_POST_HEAD = {st.ptr[PTR_IPL_HEAD][15:0], 2'b00};

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_B);

    logic [29:0] ipl_prev;
    logic [29:0] qmask_prev;
    assign ipl_prev = st.ptr[PTR_IPL_HEAD];
    assign qmask_prev = q_mask;

    chk_inbound_head_step: assert property (
        bump[PTR_IPL_HEAD] && !load[PTR_IPL_HEAD] |=>
        (INBOUND_POST_HEAD[17:2] == 16'($past(ipl_prev) + 30'h00000001)
         || ($past(ipl_prev) & $past(qmask_prev)) == $past(qmask_prev)))
        else $error("inbound head did not advance by one word");

    chk_base_readback: assert property (
        REG_SEL && !REG_WRITE && (REG_ADDR == OFS_OPL_TAIL) |=>
        REG_RDATA[31:20] == $past(QUEUE_BASE) && REG_RDATA[1:0] == 2'b00
        && REG_RDATA[19:18] == 2'b00)
        else $error("pointer read lost base or low zeros");

    chk_free_tail_step: assert property (
        bump[PTR_OFL_TAIL] && !load[PTR_OFL_TAIL] |=>
        st.ptr[PTR_OFL_TAIL] != $past(st.ptr[PTR_OFL_TAIL]))
        else $error("free tail step had no effect");

    chk_free_head_step: assert property (
        bump[PTR_OFL_HEAD] && !load[PTR_OFL_HEAD] && QUEUE_SIZE == QSIZE_64K
        && st.ptr[PTR_OFL_HEAD][15:0] != 16'hFFFF |=>
        st.ptr[PTR_OFL_HEAD] == $past(st.ptr[PTR_OFL_HEAD]) + 30'h00000001)
        else $error("free head missed outbound write");

    chk_post_tail_step: assert property (
        PCI_TGT_VALID && MSG_UNIT_ENABLE && !PCI_TGT_WRITE
        && PCI_TGT_ADDR == TGT_OUTBOUND_QUEUE && !load[PTR_OPL_TAIL] |=>
        st.ptr[PTR_OPL_TAIL] != $past(st.ptr[PTR_OPL_TAIL]) ##0 PCI_TGT_DONE)
        else $error("post tail missed outbound read");

    chk_wrap_keeps_high: assert property (
        bump[PTR_OPL_HEAD] && !load[PTR_OPL_HEAD] |=>
        (st.ptr[PTR_OPL_HEAD] & ~$past(qmask_prev))
        == ($past(st.ptr[PTR_OPL_HEAD]) & ~$past(qmask_prev)))
        else $error("step disturbed bits above the queue range");

    chk_index_alias: assert property (
        tgt_host && PCI_TGT_WRITE |=>
        st.hoia == $past(PCI_TGT_WDATA[31:WORD_LSB]) ##0 PCI_TGT_CLAIM)
        else $error("host index not shared between views");

    chk_irq_follows: assert property (
        ##1 OUTBOUND_LIST_IRQ_STATUS ==
        $past(EXT_OUTBOUND_ENABLE && (st.hoia != st.ptr[PTR_PROC_INDEX])))
        else $error("outbound status does not track index compare");

    chk_retry_disabled: assert property (
        PCI_TGT_VALID && !MSG_UNIT_ENABLE |=>
        PCI_TGT_RETRY && !PCI_TGT_DONE && !PCI_TGT_CLAIM)
        else $error("disabled unit did not retry");

    chk_step_noop: assert property (
        reg_wr && REG_ADDR == OFS_PROC_INDEX_STEP && !REG_WDATA[STEP_BIT] |=>
        $stable(st.ptr[PTR_PROC_INDEX]))
        else $error("zero step write moved the index");

    chk_proc_index_wrap: assert property (
        bump[PTR_PROC_INDEX] && HOST_LIST_SIZE == 3'h0
        && st.ptr[PTR_PROC_INDEX][7:0] == 8'hFF |=>
        st.ptr[PTR_PROC_INDEX][7:0] == 8'h00
        && st.ptr[PTR_PROC_INDEX][29:8] == $past(st.ptr[PTR_PROC_INDEX][29:8]))
        else $error("processor index did not wrap at 256 entries");

    cov_inbound_post: cover property (bump[PTR_IPL_HEAD]);
    cov_irq_rise: cover property ($rose(OUTBOUND_LIST_IRQ_STATUS));
    cov_retry: cover property (PCI_TGT_RETRY);
    cov_host_write: cover property (tgt_host && PCI_TGT_WRITE);

endmodule

`default_nettype wire

//--- src/queue_ptr_pkg.sv
package queue_ptr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // local register offsets
    localparam logic [11:0] OFS_IPL_HEAD = 12'h524;
    localparam logic [11:0] OFS_OFL_TAIL = 12'h528;
    localparam logic [11:0] OFS_OFL_TAIL_STEP = 12'h52C;
    localparam logic [11:0] OFS_OFL_HEAD = 12'h530;
    localparam logic [11:0] OFS_OPL_TAIL = 12'h534;
    localparam logic [11:0] OFS_OPL_HEAD = 12'h538;
    localparam logic [11:0] OFS_OPL_HEAD_STEP = 12'h53C;
    localparam logic [11:0] OFS_HOST_OFFSET = 12'h540;
    localparam logic [11:0] OFS_HOST_INDEX = 12'h544;
    localparam logic [11:0] OFS_PROC_INDEX = 12'h548;
    localparam logic [11:0] OFS_PROC_INDEX_STEP = 12'h54C;

    // target image locations of the two queue ports
    localparam logic [11:0] TGT_INBOUND_QUEUE = 12'h040;
    localparam logic [11:0] TGT_OUTBOUND_QUEUE = 12'h044;

    ////////////////////////////////////////////////////////////////////////////////
    // pointer slots, all held as word values (byte address bits 31:2)
    localparam int NUM_PTR = 6;
    localparam int PTR_IPL_HEAD = 0;
    localparam int PTR_OFL_TAIL = 1;
    localparam int PTR_OFL_HEAD = 2;
    localparam int PTR_OPL_TAIL = 3;
    localparam int PTR_OPL_HEAD = 4;
    localparam int PTR_PROC_INDEX = 5;

    // field positions
    localparam int STEP_BIT = 0;
    localparam int WORD_LSB = 2;
    localparam int QPTR_MSB = 17;
    localparam int HOST_OFS_MSB = 11;

    // size codes and the word bits they let advance
    localparam logic [2:0] QSIZE_1K = 3'h1;
    localparam logic [2:0] QSIZE_4K = 3'h2;
    localparam logic [2:0] QSIZE_16K = 3'h3;
    localparam logic [2:0] QSIZE_64K = 3'h4;
    localparam logic [2:0] HSIZE_256_ALT = 3'h1;
    localparam logic [2:0] HSIZE_1K = 3'h2;
    localparam logic [2:0] HSIZE_4K = 3'h4;
    localparam logic [29:0] MASK_256 = 30'h000000FF;
    localparam logic [29:0] MASK_1K = 30'h000003FF;
    localparam logic [29:0] MASK_4K = 30'h00000FFF;
    localparam logic [29:0] MASK_16K = 30'h00003FFF;
    localparam logic [29:0] MASK_64K = 30'h0000FFFF;

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [NUM_PTR-1:0][29:0] ptr;
        logic [9:0] host_ofs;
        logic [29:0] hoia;
        logic irq;
        logic ofl_empty;
        logic opl_empty;
        logic [31:0] reg_rdata;
        logic reg_ack;
        logic reg_hit;
        logic [31:0] tgt_rdata;
        logic tgt_done;
        logic tgt_retry;
        logic tgt_claim;
    } state_s;

    localparam state_s STATE_RESET = '0;

    // unlisted codes fall to the largest list so a pointer never leaves its block
    function automatic logic [29:0] queue_mask(input logic [2:0] code);
        case (code)
            3'h0: queue_mask = MASK_256;
            QSIZE_1K: queue_mask = MASK_1K;
            QSIZE_4K: queue_mask = MASK_4K;
            QSIZE_16K: queue_mask = MASK_16K;
            default: queue_mask = MASK_64K;
        endcase
    endfunction

    function automatic logic [29:0] host_mask(input logic [2:0] code);
        case (code)
            3'h0: host_mask = MASK_256;
            HSIZE_256_ALT: host_mask = MASK_256;
            HSIZE_1K: host_mask = MASK_1K;
            default: host_mask = MASK_4K;
        endcase
    endfunction

    function automatic logic [11:0] slot_offset(input int slot);
        if (slot == PTR_IPL_HEAD) slot_offset = OFS_IPL_HEAD;
        else if (slot == PTR_OFL_TAIL) slot_offset = OFS_OFL_TAIL;
        else if (slot == PTR_OFL_HEAD) slot_offset = OFS_OFL_HEAD;
        else if (slot == PTR_OPL_TAIL) slot_offset = OFS_OPL_TAIL;
        else if (slot == PTR_OPL_HEAD) slot_offset = OFS_OPL_HEAD;
        else slot_offset = OFS_PROC_INDEX;
    endfunction

endpackage

//--- src/word_stepper.sv
`timescale 1ns/100ps
`default_nettype none

// advances a word pointer by one word inside the masked bits only
module word_stepper (
    // pointer in
    input wire logic [29:0] word,
    input wire logic [29:0] wrap_mask,
    // pointer out
    output logic [29:0] stepped
);

    logic [29:0] plus_one;

    assign plus_one = word + 30'h00000001;
    // carry out of the masked range is dropped, so the pointer wraps in place
    assign stepped = (word & ~wrap_mask) | (plus_one & wrap_mask);

endmodule

`default_nettype wire

//--- verification/pci_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// host side of the target image, one pulsed request per call
module pci_host_model (
    // clock
    input wire logic clk,
    // request toward the target image
    output logic valid,
    output logic write,
    output logic [11:0] addr,
    output logic [31:0] wdata,
    // answer from the target image
    input wire logic [31:0] rdata,
    input wire logic done,
    input wire logic retry,
    input wire logic claim
);
    initial begin
        valid = 1'b0;
        write = 1'b0;
        addr = 12'h000;
        wdata = 32'h00000000;
    end

    // released lines show the inverse so a stale value never passes for a held one
    task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] rd, output logic [2:0] ans);
        @(negedge clk);
        valid = 1'b1;
        write = w;
        addr = a;
        wdata = d;
        @(negedge clk);
        valid = 1'b0;
        write = ~w;
        addr = ~a;
        wdata = ~d;
        rd = rdata;
        ans = {done, retry, claim};
    endtask
endmodule

`default_nettype wire

//--- verification/i2o_queue_pointer_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none

`define CHECK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module i2o_queue_pointer_unit_tb
    import queue_ptr_pkg::*;
;
    logic clk, rst_b, en, ext, sel, wr, ack, hit, pv, pw, pdone, pretry, pclaim;
    logic irq, fe, pe;
    logic [11:0] base, ra, pa;
    logic [2:0] qsize, hsize;
    logic [31:0] wd, rrd, pwd, prd;
    logic [17:0] ihead;
    logic [9:0] host_ofs;
    int errors, n_tests, hoia;
    int ptr [6];
    logic [11:0] ptr_ofs [5] = '{OFS_IPL_HEAD, OFS_OFL_TAIL, OFS_OFL_HEAD, OFS_OPL_TAIL,
                                 OFS_OPL_HEAD};

    i2o_queue_pointer_unit dut (.CLK_SYS(clk), .RST_B(rst_b), .QUEUE_BASE(base),
        .QUEUE_SIZE(qsize), .HOST_LIST_SIZE(hsize), .MSG_UNIT_ENABLE(en),
        .EXT_OUTBOUND_ENABLE(ext), .REG_SEL(sel), .REG_WRITE(wr), .REG_ADDR(ra),
        .REG_WDATA(wd), .REG_RDATA(rrd), .REG_ACK(ack), .REG_HIT(hit),
        .PCI_TGT_VALID(pv), .PCI_TGT_WRITE(pw), .PCI_TGT_ADDR(pa), .PCI_TGT_WDATA(pwd),
        .PCI_TGT_RDATA(prd), .PCI_TGT_DONE(pdone), .PCI_TGT_RETRY(pretry),
        .PCI_TGT_CLAIM(pclaim), .OUTBOUND_LIST_IRQ_STATUS(irq), .OUTBOUND_FREE_EMPTY(fe),
        .OUTBOUND_POST_EMPTY(pe), .INBOUND_POST_HEAD(ihead));

    pci_host_model host (.clk(clk), .valid(pv), .write(pw), .addr(pa), .wdata(pwd),
        .rdata(prd), .done(pdone), .retry(pretry), .claim(pclaim));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic int qmask(int c);
        return c == 0 ? 32'hFF : c == 1 ? 32'h3FF : c == 2 ? 32'hFFF : c == 3 ? 32'h3FFF : 32'hFFFF;
    endfunction

    function automatic int hmask(int c);
        return c < 2 ? 32'hFF : c == 2 ? 32'h3FF : 32'hFFF;
    endfunction

    // carry out of the sized field is dropped, upper bits kept
    function automatic int bump(int p, int m);
        return (p & ~m) | ((p + 1) & m);
    endfunction

    function automatic int slot_of(logic [11:0] a);
        case (a)
            OFS_IPL_HEAD: return 0;
            OFS_OFL_TAIL: return 1;
            OFS_OFL_HEAD: return 2;
            OFS_OPL_TAIL: return 3;
            OFS_OPL_HEAD: return 4;
            OFS_PROC_INDEX: return 5;
            default: return -1;
        endcase
    endfunction

    function automatic logic [32:0] exp_reg(logic [11:0] a);
        int s;
        s = slot_of(a);
        if (s == 5) return {1'b1, ptr[5][29:0], 2'b00};
        if (s >= 0) return {1'b1, base, 2'b00, ptr[s][15:0], 2'b00};
        case (a)
            OFS_HOST_OFFSET: return {1'b1, 20'h00000, host_ofs, 2'b00};
            OFS_HOST_INDEX: return {1'b1, hoia[29:0], 2'b00};
            OFS_OFL_TAIL_STEP, OFS_OPL_HEAD_STEP, OFS_PROC_INDEX_STEP: return 33'h100000000;
            default: return 33'h000000000;
        endcase
    endfunction

    task automatic model_write(logic [11:0] a, logic [31:0] d);
        int s;
        s = slot_of(a);
        if (s == 5) ptr[5] = d[31:2];
        else if (s >= 0) ptr[s] = d[17:2];
        else if (a == OFS_HOST_OFFSET) host_ofs = d[11:2];
        else if (a == OFS_HOST_INDEX) hoia = d[31:2];
        else if (d[0]) begin
            if (a == OFS_OFL_TAIL_STEP) ptr[1] = bump(ptr[1], qmask(qsize));
            if (a == OFS_OPL_HEAD_STEP) ptr[4] = bump(ptr[4], qmask(qsize));
            if (a == OFS_PROC_INDEX_STEP) ptr[5] = bump(ptr[5], hmask(hsize));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // status lags the state change by one cycle
    task automatic check_flags;
        @(negedge clk);
        `CHECK("irq_status", ext && (hoia != ptr[5]), irq)
        `CHECK("free_empty", ptr[1] == ptr[2], fe)
        `CHECK("post_empty", ptr[3] == ptr[4], pe)
        `CHECK("inbound_head", {ptr[0][15:0], 2'b00}, ihead)
    endtask

    task automatic reg_op(logic w, logic [11:0] a, logic [31:0] d);
        logic [32:0] ex;
        ex = exp_reg(a);
        @(negedge clk);
        sel = 1'b1;
        wr = w;
        ra = a;
        wd = d;
        @(negedge clk);
        sel = 1'b0;
        wr = ~w;
        ra = ~a;
        wd = ~d;
        `CHECK("reg_ack", 1'b1, ack)
        `CHECK("reg_hit", ex[32], hit)
        `CHECK("reg_rdata", w ? 32'h00000000 : ex[31:0], rrd)
        if (w) model_write(a, d);
        check_flags;
    endtask

    task automatic pci_op(logic w, logic [11:0] a, logic [31:0] d);
        logic [31:0] rd, exd;
        logic [2:0] ans;
        logic hix, cl;
        hix = (a == {host_ofs, 2'b00});
        cl = en && (hix || a == TGT_INBOUND_QUEUE || a == TGT_OUTBOUND_QUEUE);
        exd = (hix && !w) ? {hoia[29:0], 2'b00} : 32'h00000000;
        host.access(w, a, d, rd, ans);
        `CHECK("pci_answer", {en, !en, cl}, ans)
        if (en) begin
            `CHECK("pci_rdata", exd, rd)
            if (hix) begin
                if (w) hoia = d[31:2];
            end else if (a == TGT_INBOUND_QUEUE) begin
                if (w) ptr[0] = bump(ptr[0], qmask(qsize));
            end else if (a == TGT_OUTBOUND_QUEUE) begin
                if (w) ptr[2] = bump(ptr[2], qmask(qsize));
                else ptr[3] = bump(ptr[3], qmask(qsize));
            end
        end
        check_flags;
    endtask

    task automatic rand_op;
        logic [31:0] d, r;
        int m;
        r = $urandom;
        d = $urandom;
        m = qmask(qsize);
        // a full field makes the next step wrap
        if (r[20]) d[17:2] = d[17:2] | m[15:0];
        en = (r[2:0] != 3'h0);
        ext = r[3];
        case (r[7:4] % 10)
            0: reg_op(1'b1, ptr_ofs[r[10:8] % 5], d);
            1: reg_op(1'b1, OFS_OFL_TAIL_STEP, d);
            2: reg_op(1'b1, OFS_OPL_HEAD_STEP, d);
            3: reg_op(1'b1, OFS_PROC_INDEX_STEP, d);
            4: reg_op(1'b1, r[11] ? OFS_PROC_INDEX : OFS_HOST_INDEX, d);
            5: pci_op(1'b1, TGT_INBOUND_QUEUE, d);
            6: pci_op(r[12], TGT_OUTBOUND_QUEUE, d);
            7: pci_op(r[12], {host_ofs, 2'b00}, d);
            8: pci_op(r[12], {r[31:22], 2'b00}, d);
            default: reg_op(1'b0, {r[31:22], 2'b00}, d);
        endcase
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        #400000;
        errors++;
        complete_run;
    end

    initial begin
        logic [31:0] v;
        rst_b = 1'b0;
        base = 12'hA5C;
        {qsize, hsize, en, ext, sel, wr, ra, wd, host_ofs} = '0;
        errors = 0;
        n_tests = 0;
        hoia = 0;
        foreach (ptr[i]) ptr[i] = 0;
        void'($urandom(32'h6c0a8592));
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        // reset values, with one unmapped place at each end
        for (int a = 12'h520; a <= 12'h550; a += 4) reg_op(1'b0, a[11:0], 32'h00000000);
        for (int k = 0; k < 8; k++) begin
            v = $urandom;
            qsize = k[2:0];
            hsize = k[2:0];
            base = v[31:20];
            en = 1'b1;
            // equal head and tail leave every list empty
            foreach (ptr_ofs[i])
                reg_op(1'b1, ptr_ofs[i], v);
            // host index kept clear of the four reserved slots
            do v = $urandom;
            while (v[9:0] inside {10'h00C, 10'h00D, 10'h010, 10'h011});
            reg_op(1'b1, OFS_HOST_OFFSET, {20'h00000, v[9:0], 2'b00});
            repeat (40) rand_op;
            for (int a = 12'h524; a <= 12'h54C; a += 4) reg_op(1'b0, a[11:0], 32'h00000000);
        end
        complete_run;
    end
endmodule

`default_nettype wire
